//--- hw/sensor_i2c_pkg.sv
// Shared constants, states and checksum function for the sensor I2C target frames
package sensor_i2c_pkg;
  localparam logic [7:0] GENERAL_CALL_BYTE = 8'h00;
  localparam logic [1:0] READ_SEL_ONE_BYTE = 2'h1;
  localparam logic [7:0] CRC_POLY          = 8'h07;
  localparam logic [7:0] CRC_INIT          = 8'hff;
  localparam logic [7:0] PAD_BYTE          = 8'hff;
  localparam logic [2:0] STD_CRC_POS       = 3'h4;
  localparam int         WR_WORD_W         = 16;
  localparam int         WR_DEPTH          = 2;
  // Single-byte read slots
  localparam logic [3:0] SLOT_T_MSB  = 4'h0;
  localparam logic [3:0] SLOT_X_MSB  = 4'h2;
  localparam logic [3:0] SLOT_Y_MSB  = 4'h4;
  localparam logic [3:0] SLOT_Z_MSB  = 4'h6;
  localparam logic [3:0] SLOT_STATUS = 4'h8;
  localparam logic [3:0] SLOT_CRC    = 4'h9;
  localparam logic [3:0] SLOT_PAD    = 4'ha;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_TX, ST_TX_ACK
  } frame_state_e;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

//--- hw/wr_buffer.sv
// Two-entry valid/ready buffer for received write words
`timescale 1ns/100ps
module wr_buffer #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [1:0]   cnt_r, cnt_nxt;
  logic         rd_r, rd_nxt;
  logic         wr_r, wr_nxt;
  logic         push, pop;

  assign in_ready  = (cnt_r != 2'(DEPTH));
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    rd_nxt  = rd_r;
    wr_nxt  = wr_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt        = ~wr_r;
    end
    if (pop) begin
      rd_nxt = ~rd_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 2'h0;
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      cnt_r <= cnt_nxt;
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule

//--- hw/sensor_i2c_target.sv
// I2C target frame engine: general call write, standard read, single-byte read
//
// Summary of operation
// - Accept an all-zero first byte as a write addressed to this target.
// - Second byte MSB set starts a conversion after address decode.
// - Second byte low seven bits set start address; auto-increment per byte.
// - Broadcast write data bytes are stored at the addressed registers.
// - Standard read returns addressed register, advancing on each primary acknowledge except the one before the CRC byte.
// - With CRC on, standard read sends a fifth byte: CRC of four bytes.
// - Selection 01b: address-read alone starts result data at once.
// - Single-byte read sends enabled channel results then the status byte.
// - With CRC on, single-byte read appends CRC over address byte and data.
// - Channel order is temperature, X, Y, Z, skipping disabled channels.
// - Read frame format follows selection field and CRC enable.
`timescale 1ns/100ps
module sensor_i2c_target
  import sensor_i2c_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  input  wire logic [6:0]  TARGET_ADDR,
  input  wire logic [1:0]  READ_FRAME_SEL,
  input  wire logic        CRC_ENABLE,
  input  wire logic [2:0]  MAGNETIC_CHANNEL_ENABLE,
  input  wire logic        TEMPERATURE_CHANNEL_ENABLE,
  input  wire logic [7:0]  CONVERSION_STATUS_BYTE,
  input  wire logic [15:0] TEMP_RESULT,
  input  wire logic [15:0] X_RESULT,
  input  wire logic [15:0] Y_RESULT,
  input  wire logic [15:0] Z_RESULT,
  output logic      [6:0]  REG_ADDR,
  input  wire logic [7:0]  REG_RD_DATA,
  output logic             CONV_TRIGGER,
  output logic             WR_VALID,
  input  wire logic        WR_READY,
  output logic      [6:0]  WR_ADDR,
  output logic      [7:0]  WR_DATA,
  output logic             WR_BROADCAST
);
  import sensor_i2c_pkg::*;

  logic         scl_s1_r, scl_s2_r, scl_s3_r;
  logic         sda_s1_r, sda_s2_r, sda_s3_r;
  logic         scl_rise, scl_fall, start_det, stop_det;
  frame_state_e state_r, state_nxt;
  logic [2:0]   bit_r, bit_nxt;
  logic         done_r, done_nxt;
  logic [7:0]   shift_r, shift_nxt;
  logic [6:0]   addr_r, addr_nxt;
  logic         oe_n_r, oe_n_nxt;
  logic [7:0]   crc_r, crc_nxt;
  logic [2:0]   rd_cnt_r, rd_cnt_nxt;
  logic [3:0]   slot_r, slot_nxt;
  logic         slot_mode_r, slot_mode_nxt;
  logic         cmd_seen_r, cmd_seen_nxt;
  logic         bcast_r, bcast_nxt;
  logic         rw_r, rw_nxt;
  logic         mack_r, mack_nxt;
  logic         trig_r, trig_nxt;
  logic         buf_in_valid, buf_in_ready;
  logic [7:0]   tx_byte;
  logic         tx_slot_mode;
  logic [3:0]   tx_slot;
  logic [WR_WORD_W-1:0] buf_out;

  // Two-flop synchronisers, third flop for edge detection
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= SCL_IN;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= SDA_IN;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  assign scl_rise  = scl_s2_r && !scl_s3_r;
  assign scl_fall  = !scl_s2_r && scl_s3_r;
  assign start_det = scl_s2_r && scl_s3_r && !sda_s2_r && sda_s3_r;
  assign stop_det  = scl_s2_r && scl_s3_r && sda_s2_r && !sda_s3_r;

  function automatic logic slot_on(input logic [3:0] s, input logic [2:0] mag,
                                   input logic t_en, input logic crc_en);
    case (s)
      4'h0, 4'h1: slot_on = t_en;
      4'h2, 4'h3: slot_on = mag[0];
      4'h4, 4'h5: slot_on = mag[1];
      4'h6, 4'h7: slot_on = mag[2];
      SLOT_CRC:   slot_on = crc_en;
      default:    slot_on = 1'b1;
    endcase
  endfunction

  function automatic logic [3:0] slot_after(input logic [4:0] from, input logic [2:0] mag,
                                            input logic t_en, input logic crc_en);
    logic [3:0] pick;
    logic       found;
    pick  = SLOT_PAD;
    found = 1'b0;
    for (int k = 0; k <= 10; k++) begin
      if (!found && (5'(k) > from || from == 5'h1f) && slot_on(4'(k), mag, t_en, crc_en)) begin
        pick  = 4'(k);
        found = 1'b1;
      end
    end
    if (from >= 5'(SLOT_PAD) && from != 5'h1f) begin
      pick = SLOT_PAD;
    end
    return pick;
  endfunction

  // Byte to send, chosen from frame format and pointer
  always_comb begin
    tx_slot_mode = slot_mode_r;
    tx_slot      = slot_r;
    if (state_r == ST_ADDR_ACK) begin
      // Format from selection field and checksum enable
      // Direct read only without a command byte
      tx_slot_mode = !cmd_seen_r && READ_FRAME_SEL == READ_SEL_ONE_BYTE;
      tx_slot      = slot_after(5'h1f, MAGNETIC_CHANNEL_ENABLE,
                                TEMPERATURE_CHANNEL_ENABLE, CRC_ENABLE);
    end
    tx_byte = REG_RD_DATA;
    if (tx_slot_mode) begin
      case (tx_slot)
        4'h0:        tx_byte = TEMP_RESULT[15:8];
        4'h1:        tx_byte = TEMP_RESULT[7:0];
        4'h2:        tx_byte = X_RESULT[15:8];
        4'h3:        tx_byte = X_RESULT[7:0];
        4'h4:        tx_byte = Y_RESULT[15:8];
        4'h5:        tx_byte = Y_RESULT[7:0];
        4'h6:        tx_byte = Z_RESULT[15:8];
        4'h7:        tx_byte = Z_RESULT[7:0];
        SLOT_STATUS: tx_byte = CONVERSION_STATUS_BYTE;
        SLOT_CRC:    tx_byte = crc_r;
        default:     tx_byte = PAD_BYTE;
      endcase
    end else if (CRC_ENABLE && rd_cnt_r == STD_CRC_POS) begin
      tx_byte = crc_r;
    end
  end

  always_comb begin
    state_nxt     = state_r;
    bit_nxt       = bit_r;
    done_nxt      = done_r;
    shift_nxt     = shift_r;
    addr_nxt      = addr_r;
    oe_n_nxt      = oe_n_r;
    crc_nxt       = crc_r;
    rd_cnt_nxt    = rd_cnt_r;
    slot_nxt      = slot_r;
    slot_mode_nxt = slot_mode_r;
    cmd_seen_nxt  = cmd_seen_r;
    bcast_nxt     = bcast_r;
    rw_nxt        = rw_r;
    mack_nxt      = mack_r;
    trig_nxt      = 1'b0;
    buf_in_valid  = 1'b0;
    if (start_det) begin
      state_nxt  = ST_ADDR;
      bit_nxt    = 3'h0;
      rd_cnt_nxt = 3'h0;
      done_nxt  = 1'b0;
      oe_n_nxt  = 1'b1;
    end else if (stop_det) begin
      state_nxt    = ST_IDLE;
      oe_n_nxt     = 1'b1;
      cmd_seen_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise && !done_r) begin
            shift_nxt = {shift_r[6:0], sda_s2_r};
            bit_nxt   = bit_r + 3'h1;
            done_nxt  = (bit_r == 3'h7);
          end else if (scl_fall && done_r) begin
            done_nxt = 1'b0;
            bit_nxt  = 3'h0;
            if (state_r == ST_ADDR) begin
              if (shift_r == GENERAL_CALL_BYTE || shift_r[7:1] == TARGET_ADDR) begin
                oe_n_nxt  = 1'b0;
                bcast_nxt = (shift_r == GENERAL_CALL_BYTE);
                rw_nxt    = shift_r[0];
                state_nxt = ST_ADDR_ACK;
              end else begin
                state_nxt = ST_IDLE;
              end
            end else if (state_r == ST_CMD) begin
              addr_nxt     = shift_r[6:0];
              trig_nxt     = shift_r[7];
              cmd_seen_nxt = 1'b1;
              oe_n_nxt     = 1'b0;
              state_nxt    = ST_CMD_ACK;
            end else if (buf_in_ready) begin
              buf_in_valid = 1'b1;
              addr_nxt     = addr_r + 7'h1;
              oe_n_nxt     = 1'b0;
              state_nxt    = ST_WDATA_ACK;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              slot_mode_nxt = tx_slot_mode;
              slot_nxt      = slot_after({1'b0, tx_slot}, MAGNETIC_CHANNEL_ENABLE,
                                         TEMPERATURE_CHANNEL_ENABLE, CRC_ENABLE);
              // Data sent per enabled channel, then status, then checksum when enabled
              // Single-byte checksum seeded with the address byte
              crc_nxt    = crc8_step(tx_slot_mode ? crc8_step(CRC_INIT, shift_r) : CRC_INIT,
                                     tx_byte);
              rd_cnt_nxt = 3'h1;
              if (!tx_slot_mode) begin
                addr_nxt = addr_r + 7'h1;
              end
              shift_nxt = tx_byte;
              oe_n_nxt  = tx_byte[7];
              state_nxt = ST_TX;
            end else begin
              oe_n_nxt  = 1'b1;
              state_nxt = ST_CMD;
            end
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_n_nxt  = 1'b1;
            state_nxt = ST_WDATA;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_r == 3'h7) begin
              oe_n_nxt  = 1'b1;
              bit_nxt   = 3'h0;
              state_nxt = ST_TX_ACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_n_nxt  = shift_r[6];
              bit_nxt   = bit_r + 3'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            mack_nxt = !sda_s2_r;
          end else if (scl_fall) begin
            if (mack_r) begin
              shift_nxt = tx_byte;
              oe_n_nxt  = tx_byte[7];
              state_nxt = ST_TX;
              if (slot_mode_r) begin
                slot_nxt = slot_after({1'b0, slot_r}, MAGNETIC_CHANNEL_ENABLE,
                                      TEMPERATURE_CHANNEL_ENABLE, CRC_ENABLE);
                crc_nxt  = crc8_step(crc_r, tx_byte);
              end else if (CRC_ENABLE && rd_cnt_r == STD_CRC_POS) begin
                rd_cnt_nxt = 3'h0;
                crc_nxt    = CRC_INIT;
              end else begin
                rd_cnt_nxt = rd_cnt_r + 3'h1;
                crc_nxt    = crc8_step(crc_r, tx_byte);
                addr_nxt   = addr_r + 7'h1;
              end
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_r     <= ST_IDLE;
      bit_r       <= 3'h0;
      done_r      <= 1'b0;
      shift_r     <= 8'h00;
      addr_r      <= 7'h00;
      oe_n_r      <= 1'b1;
      crc_r       <= CRC_INIT;
      rd_cnt_r    <= 3'h0;
      slot_r      <= SLOT_T_MSB;
      slot_mode_r <= 1'b0;
      cmd_seen_r  <= 1'b0;
      bcast_r     <= 1'b0;
      rw_r        <= 1'b0;
      mack_r      <= 1'b0;
      trig_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      bit_r       <= bit_nxt;
      done_r      <= done_nxt;
      shift_r     <= shift_nxt;
      addr_r      <= addr_nxt;
      oe_n_r      <= oe_n_nxt;
      crc_r       <= crc_nxt;
      rd_cnt_r    <= rd_cnt_nxt;
      slot_r      <= slot_nxt;
      slot_mode_r <= slot_mode_nxt;
      cmd_seen_r  <= cmd_seen_nxt;
      bcast_r     <= bcast_nxt;
      rw_r        <= rw_nxt;
      mack_r      <= mack_nxt;
      trig_r      <= trig_nxt;
    end
  end

  wr_buffer #(
    .W     (WR_WORD_W),
    .DEPTH (WR_DEPTH)
  ) u_wr_buffer (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({bcast_r, addr_r, shift_r}),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  (buf_out)
  );

  assign WR_BROADCAST = buf_out[15];
  assign WR_ADDR      = buf_out[14:8];
  assign WR_DATA      = buf_out[7:0];
  assign SDA_OUT      = 1'b0;
  assign SDA_OE_N     = oe_n_r;
  assign REG_ADDR     = addr_r;
  assign CONV_TRIGGER = trig_r;
endmodule

//--- sim/i2c_primary_model.sv
// Behavioural I2C primary that drives the link clock and pulls the data line
`timescale 1ns/100ps
module i2c_primary_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One bit slot: data set while clock low, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #50 scl = 1'b1;
    #50 r = sda;
    #50 scl = 1'b0;
    #50;
  endtask
  // Start or repeated start: data falls while clock high
  task automatic send_start();
    sda_pull = 1'b0;
    #50 scl = 1'b1;
    #100 sda_pull = 1'b1;
    #100 scl = 1'b0;
    #50;
  endtask
  // Stop: data rises while clock high, clock then stands still
  task automatic send_stop();
    sda_pull = 1'b1;
    #50 scl = 1'b1;
    #100 sda_pull = 1'b0;
    #100;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte answered by acknowledge when ack is set, by no acknowledge otherwise
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
endmodule

//--- sim/sensor_i2c_target_checker.sv
// Concurrent checks on the sensor I2C target frame ports
`timescale 1ns/100ps
module sensor_i2c_target_checker (
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       SCL_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE_N,
  input wire logic       CONV_TRIGGER,
  input wire logic [6:0] REG_ADDR,
  input wire logic       WR_VALID,
  input wire logic       WR_READY,
  input wire logic [6:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic       WR_BROADCAST
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_open_drain: assert property (SDA_OUT == 1'b0)
    else $error("data output not low");
  a_trigger_pulse: assert property (CONV_TRIGGER |=> !CONV_TRIGGER)
    else $error("trigger longer than one cycle");
  a_word_held: assert property (WR_VALID && !WR_READY |=>
    WR_VALID && $stable({WR_ADDR, WR_DATA, WR_BROADCAST})) else $error("stalled word lost");
  a_word_leaves: assert property ($fell(WR_VALID) |-> $past(WR_READY))
    else $error("word dropped without handshake");
  a_reset_quiet: assert property (@(posedge CLOCK) disable iff (1'b0) RST |=>
    SDA_OE_N && !WR_VALID && !CONV_TRIGGER && REG_ADDR == 7'h00) else $error("reset state");
  a_drive_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
    else $error("data changed while clock high");
  a_addr_scl_low: assert property ($changed(REG_ADDR) |-> !SCL_IN)
    else $error("pointer moved while clock high");
  a_release_reset: assert property ($fell(RST) |-> SDA_OE_N [*3])
    else $error("data pulled after reset");
endmodule

bind sensor_i2c_target sensor_i2c_target_checker chk_i (.CLOCK(CLOCK), .RST(RST),
  .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .CONV_TRIGGER(CONV_TRIGGER),
  .REG_ADDR(REG_ADDR), .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_ADDR(WR_ADDR),
  .WR_DATA(WR_DATA), .WR_BROADCAST(WR_BROADCAST));

//--- sim/sensor_i2c_target_test.sv
// Self-checking bench for the sensor I2C target frames
`timescale 1ns/100ps
module sensor_i2c_target_test;
  import sensor_i2c_pkg::*;
  logic        CLOCK = 0, RST = 1, rdy = 0, hold = 0, ack, crc_en = 0, t_en = 0;
  logic [6:0]  own = 7'h35, reg_addr, wr_addr;
  logic [1:0]  sel = 2'h0;
  logic [2:0]  m_en = 3'h0;
  logic [7:0]  stat = 8'h00, rd_data, wr_data, b;
  logic [15:0] res [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [7:0]  regs [128];
  logic [15:0] wq [$];
  logic        sda_oe_n, sda_out, scl, pull, trig, wr_valid, wr_bc;
  wire         sda = (sda_oe_n | sda_out) & ~pull;
  int          errors = 0, compares = 0, cycles = 0, trigs = 0;

  assign rd_data = regs[reg_addr];
  always #12.5 CLOCK = ~CLOCK;
  always @(negedge CLOCK) rdy <= !hold && ($urandom_range(3, 0) != 0);
  always @(posedge CLOCK) begin
    cycles++;
    if (trig) trigs++;
    if (wr_valid && rdy) wq.push_back({wr_bc, wr_addr, wr_data});
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end

  sensor_i2c_target DUT (.CLOCK(CLOCK), .RST(RST), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .TARGET_ADDR(own), .READ_FRAME_SEL(sel),
    .CRC_ENABLE(crc_en), .MAGNETIC_CHANNEL_ENABLE(m_en), .TEMPERATURE_CHANNEL_ENABLE(t_en),
    .CONVERSION_STATUS_BYTE(stat), .TEMP_RESULT(res[0]), .X_RESULT(res[1]),
    .Y_RESULT(res[2]), .Z_RESULT(res[3]), .REG_ADDR(reg_addr), .REG_RD_DATA(rd_data),
    .CONV_TRIGGER(trig), .WR_VALID(wr_valid), .WR_READY(rdy), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .WR_BROADCAST(wr_bc));
  i2c_primary_model prim (.scl(scl), .sda_pull(pull), .sda(sda));

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] d [$]);
    logic [7:0] c;
    c = CRC_INIT;
    foreach (d[i]) begin
      c ^= d[i];
      repeat (8) c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  task automatic gc_write(input logic t, input logic [6:0] a, input int n, input logic full,
                          input logic bc);
    int base;
    int m;
    logic [7:0] d [$];
    base = trigs;
    m = full ? WR_DEPTH : n;
    hold = full;
    wq.delete();
    prim.send_start();
    prim.wr_byte(bc ? GENERAL_CALL_BYTE : {own, 1'b0}, ack);
    chk("address ack", 1, ack);
    prim.wr_byte({t, a}, ack);
    chk("command ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      d.push_back(8'($urandom));
      prim.wr_byte(d[i], ack);
      chk("data ack", i < m, ack);
    end
    prim.send_stop();
    hold = 0;
    repeat (40) @(negedge CLOCK);
    chk("trigger count", t, trigs - base);
    chk("word count", m, wq.size());
    for (int i = 0; i < m; i++) chk("word", {bc, a + 7'(i), d[i]}, wq[i]);
  endtask

  task automatic std_read(input logic [6:0] a);
    logic [7:0] e [$];
    for (int i = 0; i < 5; i++) e.push_back(regs[7'(a + i)]);
    if (crc_en) e[4] = crc8(e[0:3]);
    prim.send_start();
    prim.wr_byte({own, 1'b0}, ack);
    chk("write address ack", 1, ack);
    prim.wr_byte({1'b0, a}, ack);
    chk("command ack", 1, ack);
    prim.send_start();
    prim.wr_byte({own, 1'b1}, ack);
    chk("read address ack", 1, ack);
    for (int i = 0; i < 5; i++) begin
      prim.rd_byte(i < 4, b);
      chk("register byte", e[i], b);
    end
    prim.send_stop();
  endtask

  task automatic one_read();
    logic [7:0] e [$];
    e.push_back({own, 1'b1});
    for (int c = 0; c < 4; c++) begin
      if (c == 0 ? t_en : m_en[c - 1]) begin
        e.push_back(res[c][15:8]);
        e.push_back(res[c][7:0]);
      end
    end
    e.push_back(stat);
    if (crc_en) e.push_back(crc8(e));
    prim.send_start();
    prim.wr_byte(e[0], ack);
    chk("read address ack", 1, ack);
    for (int i = 1; i < e.size(); i++) begin
      prim.rd_byte(i < e.size() - 1, b);
      chk("result byte", e[i], b);
    end
    prim.send_stop();
  endtask

  task automatic complete_run();
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    void'($urandom(99261));
    foreach (regs[i]) regs[i] = 8'($urandom);
    repeat (10) @(negedge CLOCK);
    RST = 0;
    @(negedge CLOCK);
    chk("reset state", 16'h0001, {trig, wr_valid, reg_addr, sda_oe_n});
    repeat (4) @(negedge CLOCK);
    for (int t = 0; t < 2; t++) gc_write(t[0], 7'($urandom), 2, 1'b0, !t[0]);
    gc_write(1'b1, 7'h7f, 3, 1'b1, 1'b1);
    prim.send_start();
    prim.wr_byte({own ^ 7'h01, 1'b0}, ack);
    chk("foreign address ack", 0, ack);
    prim.send_stop();
    for (int k = 0; k < 4; k++) begin
      @(negedge CLOCK);
      crc_en = k[0];
      sel = k[1] ? READ_SEL_ONE_BYTE : 2'h0;
      std_read(k == 3 ? 7'h7e : 7'($urandom));
    end
    sel = READ_SEL_ONE_BYTE;
    for (int k = 0; k < 12; k++) begin
      @(negedge CLOCK);
      {t_en, m_en, crc_en} = (k == 0) ? 5'h1f : (k == 1) ? 5'h00 : 5'($urandom);
      stat = 8'($urandom);
      foreach (res[i]) res[i] = 16'($urandom);
      one_read();
    end
    complete_run();
  end
endmodule
